// ===== logic/bwe_pkg.sv
// bwe_pkg: constants for the host-side byte-wide eeprom controller
// assumes a 40 MHz system clock; all counts derived from printed times
package bwe_pkg;
    // system clock period in picoseconds
    localparam int ClkPeriodPs = 25000;
    // address and data widths of the memory port
    localparam int AddrWidth = 11;
    localparam int DataWidth = 8;
    // strobe low time, ns; well above the 20 ns noise filter
    localparam int StrobeLowNs = 150;
    localparam int StrobeLowCyc = (StrobeLowNs * 1000 + ClkPeriodPs - 1)
        / ClkPeriodPs;
    // setup and hold around strobes, ns
    localparam int SetupNs = 10;
    localparam int SetupCyc = (SetupNs * 1000 + ClkPeriodPs - 1)
        / ClkPeriodPs;
    // read access time, ns
    localparam int AccessNs = 450;
    localparam int AccessCyc = (AccessNs * 1000 + ClkPeriodPs - 1)
        / ClkPeriodPs;
    // strobe high recovery between accesses, ns
    localparam int RecoverNs = 150;
    localparam int RecoverCyc = (RecoverNs * 1000 + ClkPeriodPs - 1)
        / ClkPeriodPs;
    // maximum internal programming time, ms
    localparam int WriteMaxMs = 10;
    localparam int WriteMaxCyc = WriteMaxMs * 40000;
    // width of the shared timing counter
    localparam int CntWidth = 20;
    // controller states, one-hot
    typedef enum logic [6:0] {
        BWE_IDLE = 7'h01,
        BWE_RSETUP = 7'h02,
        BWE_RACC = 7'h04,
        BWE_WSETUP = 7'h08,
        BWE_WPULSE = 7'h10,
        BWE_WHOLD = 7'h20,
        BWE_WBUSY = 7'h40
    } bwe_state_t;
endpackage : bwe_pkg

// ===== logic/bwe_timer.sv
// bwe_timer: loadable down-counter giving a one-cycle done pulse
// assumes the owner loads it when a timed phase begins
`timescale 1ns/1ps
`default_nettype none
module bwe_timer #(
    parameter int Width = 20
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // load request and count
    input wire logic load,
    input wire logic [Width-1:0] count,
    // terminal count pulse
    output logic done
);
    logic [Width-1:0] cntReg; // remaining cycles
    logic runReg; // counting active
    assign done = runReg && (cntReg == '0);
    // count down; a fresh load always wins
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cntReg <= '0;
            runReg <= 1'b0;
        end
        else if (load)
        begin
            cntReg <= count;
            runReg <= 1'b1;
        end
        else if (runReg)
        begin
            if (cntReg == '0)
                runReg <= 1'b0;
            else
                cntReg <= cntReg - 1'b1;
        end
    end
endmodule : bwe_timer
`default_nettype wire

// ===== logic/bwe_host.sv
// bwe_host: host controller driving a 2048 x 8 byte-wide eeprom
// assumes pins are synchronous to clk; chip select is decoded from state, not from addrDecodeHit
// Contract
// - write needs select, strobe low, enable high
// - host polls known byte until match
// - hold inhibit state at power transitions
// - chip select from decode, others shared; here chipSel_b is decoded from state and addrDecodeHit is unused
`timescale 1ns/1ps
`default_nettype none
module bwe_host #(
    parameter int AddrWidth = bwe_pkg::AddrWidth,
    parameter int DataWidth = bwe_pkg::DataWidth,
    parameter int WriteMaxCyc = bwe_pkg::WriteMaxCyc
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // user request side
    input wire logic reqValid,
    output logic reqReady,
    input wire logic reqWrite,
    input wire logic [AddrWidth-1:0] reqAddr,
    input wire logic [DataWidth-1:0] reqData,
    input wire logic pollEnable,
    input wire logic [AddrWidth-1:0] pollAddr,
    input wire logic [DataWidth-1:0] pollData,
    // user answer side
    output logic rspValid,
    output logic [DataWidth-1:0] rspData,
    output logic busy,
    // memory pins
    input wire logic [AddrWidth-1:0] addrDecodeHit,
    output logic chipSel_b,
    output logic outEn_b,
    output logic writeStb_b,
    output logic [AddrWidth-1:0] location_select_lines,
    input wire logic [DataWidth-1:0] byteLinesIn,
    output logic [DataWidth-1:0] byteLinesOut,
    output logic byteLinesOe
);
    localparam int CW = bwe_pkg::CntWidth;
    bwe_pkg::bwe_state_t stateReg, stateNext;
    logic [AddrWidth-1:0] addrReg; // held address
    logic [DataWidth-1:0] dataReg; // held write data
    logic [DataWidth-1:0] rspDataReg; // captured read byte
    logic rspValidReg; // answer pulse
    logic pollingReg; // current read is a completion poll
    logic tLoad; // restart timer
    logic [CW-1:0] tCount; // timer load value
    logic tDone; // timer expired
    logic pollMatch; // poll read equals known byte

    // one cycle load is count + 1 cycles of wait
    function automatic logic [CW-1:0] cyc(input int n);
        cyc = CW'(n > 1 ? n - 1 : 0);
    endfunction : cyc

    bwe_timer #(.Width(CW)) uTimer (
        .clk(clk),
        .rst_b(rst_b),
        .load(tLoad),
        .count(tCount),
        .done(tDone)
    );

    // unused decode input kept for future array use
    wire unusedHit = |addrDecodeHit;

    // handshake and pins decoded from state
    assign reqReady = (stateReg == bwe_pkg::BWE_IDLE);
    assign busy = !reqReady;
    // chip select high only in idle and in the non-polling write wait, low through poll recovery; high at reset
    assign chipSel_b = (stateReg == bwe_pkg::BWE_IDLE) ||
        (stateReg == bwe_pkg::BWE_WBUSY && !pollingReg);
    // output enable low only in a read; high through writes
    assign outEn_b = !(stateReg == bwe_pkg::BWE_RACC);
    // write strobe low only in the timed pulse
    assign writeStb_b = !(stateReg == bwe_pkg::BWE_WPULSE);
    // drive byte lines only across a write, never while reading
    assign byteLinesOe = (stateReg == bwe_pkg::BWE_WSETUP) ||
        (stateReg == bwe_pkg::BWE_WPULSE) ||
        (stateReg == bwe_pkg::BWE_WHOLD);
    assign byteLinesOut = dataReg;
    assign location_select_lines = addrReg;
    assign rspValid = rspValidReg;
    assign rspData = rspDataReg;
    assign pollMatch = (byteLinesIn == pollData);

    // next state and timer loads
    always_comb
    begin
        stateNext = stateReg;
        tLoad = 1'b0;
        tCount = '0;
        case (stateReg)
            bwe_pkg::BWE_IDLE:
                if (reqValid)
                begin
                    tLoad = 1'b1;
                    tCount = cyc(bwe_pkg::SetupCyc);
                    stateNext = reqWrite ? bwe_pkg::BWE_WSETUP
                        : bwe_pkg::BWE_RSETUP;
                end
            bwe_pkg::BWE_RSETUP:
                if (tDone)
                begin
                    tLoad = 1'b1;
                    tCount = cyc(bwe_pkg::AccessCyc);
                    stateNext = bwe_pkg::BWE_RACC;
                end
            bwe_pkg::BWE_RACC:
                if (tDone)
                begin
                    // a failed poll goes back to waiting
                    tLoad = 1'b1;
                    tCount = cyc(bwe_pkg::RecoverCyc);
                    stateNext = (pollingReg && !pollMatch) ?
                        bwe_pkg::BWE_WBUSY : bwe_pkg::BWE_IDLE;
                end
            bwe_pkg::BWE_WSETUP:
                if (tDone)
                begin
                    tLoad = 1'b1;
                    tCount = cyc(bwe_pkg::StrobeLowCyc);
                    stateNext = bwe_pkg::BWE_WPULSE;
                end
            bwe_pkg::BWE_WPULSE:
                if (tDone)
                begin
                    tLoad = 1'b1;
                    tCount = cyc(bwe_pkg::SetupCyc);
                    stateNext = bwe_pkg::BWE_WHOLD;
                end
            bwe_pkg::BWE_WHOLD:
                if (tDone)
                begin
                    // no access during programming unless polling, which reads after the recovery wait
                    tLoad = 1'b1;
                    tCount = pollEnable ? cyc(bwe_pkg::RecoverCyc)
                        : cyc(WriteMaxCyc);
                    stateNext = bwe_pkg::BWE_WBUSY;
                end
            bwe_pkg::BWE_WBUSY:
                if (tDone)
                begin
                    tLoad = 1'b1;
                    tCount = cyc(bwe_pkg::SetupCyc);
                    stateNext = pollingReg ? bwe_pkg::BWE_RSETUP
                        : bwe_pkg::BWE_IDLE;
                end
            default:
                stateNext = bwe_pkg::BWE_IDLE;
        endcase
    end

    // state register
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            stateReg <= bwe_pkg::BWE_IDLE;
        else
            stateReg <= stateNext;
    end

    // request capture and poll flag
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            addrReg <= '0;
            dataReg <= '0;
            pollingReg <= 1'b0;
        end
        else if (stateReg == bwe_pkg::BWE_IDLE && reqValid)
        begin
            addrReg <= reqAddr;
            dataReg <= reqData;
            pollingReg <= 1'b0;
        end
        else if (stateReg == bwe_pkg::BWE_WHOLD && tDone && pollEnable)
        begin
            // poll the known location after programming starts
            addrReg <= pollAddr;
            pollingReg <= 1'b1;
        end
        else if (stateReg == bwe_pkg::BWE_RACC && tDone && pollMatch)
            pollingReg <= 1'b0;
    end

    // read data capture at end of access
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rspDataReg <= '0;
            rspValidReg <= 1'b0;
        end
        else
        begin
            rspValidReg <= 1'b0;
            if (stateReg == bwe_pkg::BWE_RACC && tDone && !pollingReg)
            begin
                rspDataReg <= byteLinesIn;
                rspValidReg <= 1'b1;
            end
            else if (stateReg == bwe_pkg::BWE_RACC && tDone && pollMatch)
                rspValidReg <= 1'b1; // write completion after poll
        end
    end
endmodule : bwe_host
`default_nettype wire

// ===== dv/bwe_host_checker.sv
// bwe_host_checker: pin properties of the host controller
// assumes it is bound to bwe_host and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module bwe_host_checker #(
    parameter int WriteMaxCyc = 50
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // mode
    input wire logic pollEnable,
    // memory pins
    input wire logic chipSel_b,
    input wire logic outEn_b,
    input wire logic writeStb_b,
    input wire logic [10:0] location_select_lines,
    input wire logic [7:0] byteLinesOut,
    input wire logic byteLinesOe
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // cycles since the strobe last stood low, saturating
    logic [19:0] sinceWr_reg;
    // starts saturated so the first access after reset is legal
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            sinceWr_reg <= 20'(WriteMaxCyc);
        else if (!writeStb_b)
            sinceWr_reg <= 20'h0;
        else if (sinceWr_reg < 20'(WriteMaxCyc))
            sinceWr_reg <= sinceWr_reg + 20'h1;
    end
    sequence s_wlow; !writeStb_b [*6]; endsequence
    sequence s_whold; writeStb_b && byteLinesOe && !chipSel_b; endsequence
    property p_wrwalk; $fell(writeStb_b) |-> s_wlow ##1 s_whold; endproperty
    a_wrwalk: assert property (p_wrwalk)
        else $error("write strobe walk broken");
    property p_wrmode; !writeStb_b |-> !chipSel_b && outEn_b; endproperty
    a_wrmode: assert property (p_wrmode)
        else $error("write strobe without select or with enable");
    property p_wrstable;
        $fell(writeStb_b) |->
            ($stable(byteLinesOut) && $stable(location_select_lines)) [*7];
    endproperty
    a_wrstable: assert property (p_wrstable)
        else $error("address or data moved during write");
    property p_inhibit; !outEn_b |-> writeStb_b && !byteLinesOe; endproperty
    a_inhibit: assert property (p_inhibit)
        else $error("write or drive while output enabled");
    property p_rdsel; $fell(outEn_b) |-> (!outEn_b && !chipSel_b) [*8];
    endproperty
    a_rdsel: assert property (p_rdsel)
        else $error("read not held under select");
    property p_wait;
        $fell(chipSel_b) && !pollEnable |-> sinceWr_reg >= 20'(WriteMaxCyc);
    endproperty
    a_wait: assert property (p_wait)
        else $error("access before write time ran out");
endmodule : bwe_host_checker
bind bwe_host bwe_host_checker #(.WriteMaxCyc(WriteMaxCyc)) i_chk (
    .clk(clk), .rst_b(rst_b), .pollEnable(pollEnable),
    .chipSel_b(chipSel_b), .outEn_b(outEn_b), .writeStb_b(writeStb_b),
    .location_select_lines(location_select_lines),
    .byteLinesOut(byteLinesOut), .byteLinesOe(byteLinesOe));
`default_nettype wire

// ===== dv/bwe_mem_model.sv
// bwe_mem_model: behavioural byte-wide eeprom facing the host
// assumes active-low strobes; event driven, no clock
`timescale 1ns/1ps
`default_nettype none
module bwe_mem_model #(
    parameter int ProgNs = 810 // off the clock grid to avoid races
) (
    // strobes
    input wire logic chipSel_b,
    input wire logic outEn_b,
    input wire logic writeStb_b,
    // address and data
    input wire logic [10:0] location_select_lines,
    input wire logic [7:0] hostData,
    output logic [7:0] byteLines
);
    logic [7:0] mem [2048]; // storage, erased to zero
    logic [10:0] wrAddr; // address taken at write start
    logic [7:0] lastByte; // last byte driven out
    logic armed; // write begun, waiting for rise
    logic prog; // internal programming busy
    realtime tFall; // moment the write began
    wire logic rdOn = !chipSel_b && !outEn_b && writeStb_b
        && !prog;
    // released lines show the inverse, never a stale copy
    assign byteLines = rdOn ? mem[location_select_lines]
        : ~lastByte;
    initial
    begin
        foreach (mem[i]) mem[i] = 8'h00;
        lastByte = 8'h00;
        armed = 1'b0;
        prog = 1'b0;
    end
    always @*
        if (rdOn) lastByte = mem[location_select_lines];
    // address on the later falling strobe; busy or enabled blocks it
    always @(negedge chipSel_b or negedge writeStb_b)
    begin
        if (!chipSel_b && !writeStb_b && outEn_b
            && !prog)
        begin
            wrAddr = location_select_lines;
            tFall = $realtime;
            armed = 1'b1;
        end
    end
    // data on the first rising strobe; short pulses are noise
    always @(posedge chipSel_b or posedge writeStb_b)
    begin
        if (armed)
        begin
            armed = 1'b0;
            if ($realtime - tFall >= 20.0)
            begin
                mem[wrAddr] = hostData;
                prog = 1'b1;
                #(ProgNs);
                prog = 1'b0;
            end
        end
    end
endmodule : bwe_mem_model
`default_nettype wire

// ===== dv/testbench.sv
// testbench: host controller against the eeprom model
// assumes a short write wait parameter to keep the run brief
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam int WrCyc = 50; // shortened write wait
    logic clk, rst_b, reqValid, reqWrite, pollEnable, reqReady, rspValid;
    logic chipSel_b, outEn_b, writeStb_b, byteLinesOe, busy;
    logic [10:0] reqAddr, pollAddr, location_select_lines;
    logic [7:0] reqData, pollData, rspData, byteLinesOut, memOut;
    // host data wins while it drives, else the model's lines
    wire logic [7:0] byteWire = byteLinesOe ? byteLinesOut : memOut;
    int n_errors, n_tests;
    bwe_host #(.WriteMaxCyc(WrCyc)) i_dut (.clk(clk), .rst_b(rst_b),
        .reqValid(reqValid), .reqReady(reqReady), .reqWrite(reqWrite),
        .reqAddr(reqAddr), .reqData(reqData), .pollEnable(pollEnable),
        .pollAddr(pollAddr), .pollData(pollData), .rspValid(rspValid),
        .rspData(rspData), .busy(busy), .addrDecodeHit(11'h000),
        .chipSel_b(chipSel_b), .outEn_b(outEn_b), .writeStb_b(writeStb_b),
        .location_select_lines(location_select_lines),
        .byteLinesIn(byteWire), .byteLinesOut(byteLinesOut),
        .byteLinesOe(byteLinesOe));
    bwe_mem_model i_mem (.chipSel_b(chipSel_b), .outEn_b(outEn_b),
        .writeStb_b(writeStb_b),
        .location_select_lines(location_select_lines),
        .hostData(byteWire), .byteLines(memOut));
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic check(input logic [7:0] s, input logic [7:0] e);
        n_tests++;
        if (s !== e)
        begin
            n_errors++;
            $display("unexpected at %0t: got %h want %h", $time, s, e);
        end
    endtask : check
    // request held from a falling edge until a rising edge takes it
    task automatic req(input logic w, input logic [10:0] a,
        input logic [7:0] d);
        reqWrite = w;
        reqAddr = a;
        reqData = d;
        reqValid = 1'b1;
        while (reqReady !== 1'b1) @(negedge clk);
        @(negedge clk);
        reqValid = 1'b0;
    endtask : req
    // bounded wait on the one-cycle answer pulse
    task automatic waitRsp(output logic [7:0] d);
        int c;
        c = 0;
        while (rspValid !== 1'b1 && c < 400)
        begin
            @(negedge clk);
            c++;
        end
        d = rspData;
        if (c >= 400) check(8'h00, 8'h01);
        @(negedge clk);
    endtask : waitRsp
    task automatic readChk(input logic [10:0] a, input logic [7:0] e);
        logic [7:0] d;
        req(1'b0, a, 8'h00);
        waitRsp(d);
        check(d, e);
    endtask : readChk
    task automatic t_nopoll;
        int c;
        c = 0;
        pollEnable = 1'b0;
        req(1'b1, 11'h7ff, 8'ha5);
        check(8'(busy), 8'h01);
        while (reqReady !== 1'b1 && c < 400)
        begin
            @(negedge clk);
            c++;
        end
        check(8'(c >= WrCyc && c < 400), 8'h01);
        check(8'(busy), 8'h00);
        readChk(11'h7ff, 8'ha5);
        readChk(11'h000, 8'h00);
        $display("test nopoll done");
    endtask : t_nopoll
    // back-to-back writes are lost if the host resumes too early
    task automatic t_poll;
        logic [7:0] d;
        pollEnable = 1'b1;
        req(1'b1, 11'h123, 8'h3c);
        waitRsp(d);
        req(1'b1, 11'h124, 8'h5a);
        waitRsp(d);
        readChk(11'h123, 8'h3c);
        readChk(11'h124, 8'h5a);
        $display("test poll done");
    endtask : t_poll
    task automatic t_reset;
        pollEnable = 1'b0;
        req(1'b1, 11'h055, 8'h11);
        repeat (3) @(negedge clk);
        rst_b = 1'b0;
        @(negedge clk);
        check({chipSel_b, outEn_b, writeStb_b, byteLinesOe, 4'h0},
            8'he0);
        rst_b = 1'b1;
        repeat (40) @(negedge clk);
        readChk(11'h7ff, 8'ha5);
        $display("test reset done");
    endtask : t_reset
    task automatic conclude;
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : conclude
    initial
    begin
        {rst_b, reqValid, reqWrite, pollEnable} = 4'h0;
        {reqAddr, pollAddr, reqData, pollData} = 38'h0;
        n_errors = 0;
        n_tests = 0;
        repeat (3) @(negedge clk);
        rst_b = 1'b1;
        @(negedge clk);
        t_nopoll();
        t_poll();
        t_reset();
        conclude();
    end
    // watchdog well past the expected few hundred cycles
    initial
    begin
        repeat (5000) @(posedge clk);
        n_errors++;
        conclude();
    end
endmodule : testbench
`default_nettype wire
